// >>> rtl/aor_relay_logic.sv
// Alarm output relay logic: combining, latching, acknowledge, reflash, fault de-energize
// How it works
// - Hold relay stays on after its condition clears until acknowledged.
// - Non-hold relay drops as soon as its condition goes away.
// - Normal ack drops hold relay, re-activates if condition seen within 100 ms.
// - Reset ack drops relay; it returns only on a fresh condition.
// - Individual ack enabled forces reset ack action.
// - AND mode: on only while every assigned alarm is active together.
// - OR mode: on while any assigned alarm is active.
// - Reflash: a further alarm while on briefly releases the relay.
// - Reflash release lasts 500 ms, 1 s or 2 s, selectable.
// - Reflash relays always combine with OR and act non-hold.
// - Polarity select; de-energize option energizes coil when no alarm.
// - Global ack clears the held indications of alarms no longer active, and held relays.
// - Individual ack releases only the selected alarm.
// - System fault de-energizes relays configured for fault indication.
// - Crash or acquisition CPU fault de-energizes relays of all units.
// - Expansion CPU fault de-energizes only that sub unit's relays.
// - Broken link de-energizes that sub unit and all units after it.
// - Restored link returns relays to normal alarm-driven operation.
// - Fault indication relays have fixed de-energize polarity.
`timescale 1ns/1ns
module aor_relay_logic #(
	parameter logic [aor_pkg::CNT_W-1:0] ACK_WIN_CYC = aor_pkg::ACK_WIN_CYC,
	parameter logic [aor_pkg::CNT_W-1:0] REFL_A_CYC  = aor_pkg::REFL_A_CYC,
	parameter logic [aor_pkg::CNT_W-1:0] REFL_B_CYC  = aor_pkg::REFL_B_CYC,
	parameter logic [aor_pkg::CNT_W-1:0] REFL_C_CYC  = aor_pkg::REFL_C_CYC
) (
	// Clock and reset
	input  wire logic                             ref_clk,
	input  wire logic                             nrst,
	// Register port
	input  wire logic [7:0]                       reg_addr,
	input  wire logic [31:0]                      reg_wdata,
	input  wire logic                             reg_wr,
	input  wire logic                             reg_rd,
	output logic      [31:0]                      reg_rdata,
	// Alarm engine and operator controls
	input  wire logic [aor_pkg::NUM_ALARMS-1:0]   alarm_act,
	input  wire aor_pkg::aor_ack_t                ack,
	input  wire aor_pkg::aor_fault_t              fault,
	// Relay coils and indications
	output logic      [aor_pkg::NUM_RELAYS-1:0]   relay_coil,
	output logic      [aor_pkg::NUM_ALARMS-1:0]   alarm_held
);
	import aor_pkg::*;

	// Configuration and control registers
	aor_cfg_t              cfg_q [NUM_RELAYS];
	logic [NUM_ALARMS-1:0] mask_q [NUM_RELAYS];
	logic [31:0]           ctrl_q;
	logic [31:0]           rdata_q;

	// Held indications and alarm history for edge detection
	logic [NUM_ALARMS-1:0] held_q;
	logic [NUM_ALARMS-1:0] held_d;
	logic [NUM_ALARMS-1:0] prev_q;

	// Coil drive and relay activity
	logic [NUM_RELAYS-1:0] coil_q;
	logic [NUM_RELAYS-1:0] coil_d;
	logic [NUM_RELAYS-1:0] relay_on;

	// Unit health along the expansion chain
	logic [NUM_UNITS-1:0]  unit_dead;
	logic [NUM_UNITS-1:0]  link_cut;

	// Address decode; paged registers take word aligned offsets only
	wire                   word_ok   = (reg_addr[1:0] == 2'h0);
	wire                   sel_cfg   = (reg_addr[7:5] == PAGE_CFG) && word_ok;
	wire                   sel_mask  = (reg_addr[7:5] == PAGE_MASK) && word_ok;
	wire                   sel_ctrl  = (reg_addr == ADDR_CTRL);
	wire                   sel_stat  = (reg_addr == ADDR_STATUS);
	wire                   sel_held  = (reg_addr == ADDR_HELD);
	wire [2:0]             reg_idx   = reg_addr[4:2];

	// Write enables, one per register group
	wire                   wr_ctrl   = reg_wr && sel_ctrl;
	wire                   wr_cfg    = reg_wr && sel_cfg;
	wire                   wr_mask   = reg_wr && sel_mask;
	wire                   indiv_en  = ctrl_q[CTRL_INDIV_BIT];
	wire aor_cfg_t         wr_cfg_v  = aor_cfg_t'(reg_wdata[$bits(aor_cfg_t)-1:0]);
	wire aor_cfg_t         cfg_store = '{unit: wr_cfg_v.unit, fail: wr_cfg_v.fail,
		deen: wr_cfg_v.deen | wr_cfg_v.fail, ivl: wr_cfg_v.ivl,
		ack_reset: wr_cfg_v.ack_reset, hold: wr_cfg_v.hold, mode: wr_cfg_v.mode};
	wire [31:0]            status_v  = {12'h000, unit_dead, coil_q, relay_on};

	// Acknowledge decode
	wire                   ack_one_ok = ack.one && indiv_en;
	wire [NUM_ALARMS-1:0]  ack_onehot = NUM_ALARMS'(1) << ack.idx;
	wire [NUM_ALARMS-1:0]  held_clr   = ack.all ? {NUM_ALARMS{1'b1}} :
		(ack_one_ok ? ack_onehot : {NUM_ALARMS{1'b0}});

	// Read data select, unmapped addresses read zero
	logic [31:0] rd_sel;
	always_comb begin
		rd_sel = 32'h0000_0000;
		if (sel_ctrl) begin
			rd_sel = ctrl_q;
		end else if (sel_stat) begin
			rd_sel = status_v;
		end else if (sel_held) begin
			rd_sel = {16'h0000, held_q};
		end else if (sel_cfg) begin
			rd_sel = {22'h00_0000, cfg_q[reg_idx]};
		end else if (sel_mask) begin
			rd_sel = {16'h0000, mask_q[reg_idx]};
		end
	end

	// Register writes and read data, read data only in the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ctrl_q  <= CTRL_RST;
			rdata_q <= 32'h0000_0000;
			for (int r = 0; r < NUM_RELAYS; r++) begin
				cfg_q[r]  <= CFG_RST;
				mask_q[r] <= MASK_RST;
			end
		end else begin
			rdata_q <= reg_rd ? rd_sel : 32'h0000_0000;
			if (wr_ctrl) begin
				ctrl_q <= {31'h0000_0000, reg_wdata[CTRL_INDIV_BIT]};
			end
			if (wr_cfg) begin
				cfg_q[reg_idx] <= cfg_store;
			end
			if (wr_mask) begin
				mask_q[reg_idx] <= reg_wdata[NUM_ALARMS-1:0];
			end
		end
	end

	// Held indications: a new alarm in the ack cycle stays shown
	assign held_d = (held_q & ~held_clr) | alarm_act;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			held_q <= {NUM_ALARMS{1'b0}};
			prev_q <= {NUM_ALARMS{1'b0}};
		end else begin
			held_q <= held_d;
			prev_q <= alarm_act;
		end
	end

	// Unit fault map; a cut link takes down every unit further along the chain
	assign link_cut[0]  = 1'b0;
	assign unit_dead[0] = fault.crash | fault.acq_cpu;
	for (genvar gu = 1; gu < NUM_UNITS; gu++) begin : g_unit
		assign link_cut[gu]  = link_cut[gu-1] | fault.link_down[gu-1];
		assign unit_dead[gu] = fault.crash | fault.acq_cpu | fault.exp_cpu[gu-1]
			| link_cut[gu];
	end

	// Per relay state machine and coil drive
	for (genvar gi = 0; gi < NUM_RELAYS; gi++) begin : g_rly
		aor_state_t        st_q;
		aor_state_t        st_d;
		logic [CNT_W-1:0]  cnt_q;
		logic [CNT_W-1:0]  cnt_d;
		logic              pend_q;
		logic              pend_d;
		logic              armed_q;
		logic              armed_d;
		logic [CNT_W-1:0]  ivl_cyc;

		// This relay's configuration and its assigned alarms
		wire aor_cfg_t        cfg     = cfg_q[gi];
		wire [NUM_ALARMS-1:0] mask    = mask_q[gi];
		wire [NUM_ALARMS-1:0] hits    = alarm_act & mask;

		// Combining; an empty mask never satisfies AND
		wire                  any_hit = |hits;
		wire                  all_hit = (mask != MASK_RST) && (hits == mask);

		// Reflash overrides both the combining mode and the hold choice
		wire                  refl    = (cfg.mode == MODE_REFL);
		wire                  or_mode = refl || (cfg.mode == MODE_OR);
		wire                  cond    = or_mode ? any_hit : all_hit;
		wire                  hold_ef = cfg.hold && !refl;

		// Acknowledge action and whether this relay is addressed
		wire                  ack_rst = cfg.ack_reset || indiv_en;
		wire                  ack_hit = ack.all || (ack_one_ok && mask[ack.idx]);

		// Events, shared timer and fault view of this relay's unit
		wire                  rise    = |(hits & ~prev_q);
		wire                  expired = (cnt_q == {CNT_W{1'b0}});
		wire                  fail_on = fault.sys_fault || unit_dead[cfg.unit];

		// Release interval select
		always_comb begin
			case (cfg.ivl)
				IVL_1S:  ivl_cyc = REFL_B_CYC;
				IVL_2S:  ivl_cyc = REFL_C_CYC;
				default: ivl_cyc = REFL_A_CYC;
			endcase
		end

		// Next state; the counter serves both the ack window and the reflash release
		always_comb begin
			st_d    = st_q;
			cnt_d   = expired ? cnt_q : cnt_q - CNT_W'(1);
			pend_d  = pend_q;
			armed_d = armed_q | ~cond;
			case (st_q)
				ST_OFF: begin
					if (cond && armed_q) begin
						st_d = ST_ON;
					end
				end
				ST_ON: begin
					if (refl) begin
						if (!any_hit) begin
							st_d = ST_OFF;
						end else if (rise) begin
							st_d  = ST_REFL;
							cnt_d = ivl_cyc;
						end
					end else if (!hold_ef) begin
						if (!cond) begin
							st_d = ST_OFF;
						end
					end else if (ack_hit) begin
						if (ack_rst) begin
							st_d    = ST_OFF;
							armed_d = ~cond;
						end else begin
							st_d   = ST_ACK;
							cnt_d  = ACK_WIN_CYC;
							pend_d = 1'b0;
						end
					end
				end
				ST_ACK: begin
					pend_d = pend_q | cond;
					if (!hold_ef) begin
						st_d = cond ? ST_ON : ST_OFF;
					end else if (expired) begin
						st_d = (pend_q || cond) ? ST_ON : ST_OFF;
					end
				end
				ST_REFL: begin
					if (!refl) begin
						st_d = ST_OFF;
					end else if (rise) begin
						cnt_d = ivl_cyc;
					end else if (expired) begin
						st_d = any_hit ? ST_ON : ST_OFF;
					end
				end
				default: begin
					st_d = ST_OFF;
				end
			endcase
		end

		// Hold relays stay in ST_ON with the condition gone until an ack arrives
		assign relay_on[gi] = (st_q == ST_ON);

		// Coil drive; fault relays fall on fault, dead units drop every coil
		always_comb begin
			if (cfg.fail) begin
				coil_d[gi] = ~fail_on;
			end else if (unit_dead[cfg.unit]) begin
				coil_d[gi] = 1'b0;
			end else begin
				coil_d[gi] = cfg.deen ? ~relay_on[gi] : relay_on[gi];
			end
		end

		// State registers
		always_ff @(posedge ref_clk) begin
			if (!nrst) begin
				st_q    <= ST_OFF;
				cnt_q   <= ACK_WIN_CYC - ACK_WIN_CYC;
				pend_q  <= 1'b0;
				armed_q <= 1'b1;
			end else begin
				st_q    <= st_d;
				cnt_q   <= cnt_d;
				pend_q  <= pend_d;
				armed_q <= armed_d;
			end
		end
	end

	// Coil outputs registered; all coils released in reset
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			coil_q <= {NUM_RELAYS{1'b0}};
		end else begin
			coil_q <= coil_d;
		end
	end

	assign reg_rdata  = rdata_q;
	assign relay_coil = coil_q;
	assign alarm_held = held_q;

endmodule // aor_relay_logic

// >>> rtl/aor_pkg.sv
// Shared constants, types and register map of the alarm output relay logic
package aor_pkg;

	// Sizes
	localparam int NUM_ALARMS = 16;
	localparam int NUM_RELAYS = 8;
	localparam int NUM_UNITS  = 4;
	localparam int NUM_SUBS   = 3;
	localparam int CNT_W      = 28;

	// Clock rate and timing, times in milliseconds
	localparam int unsigned CLK_HZ     = 125_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned ACK_WIN_MS = 100;
	localparam int unsigned REFL_A_MS  = 500;
	localparam int unsigned REFL_B_MS  = 1000;
	localparam int unsigned REFL_C_MS  = 2000;
	localparam logic [CNT_W-1:0] ACK_WIN_CYC = CNT_W'(ACK_WIN_MS * CYC_PER_MS);
	localparam logic [CNT_W-1:0] REFL_A_CYC  = CNT_W'(REFL_A_MS * CYC_PER_MS);
	localparam logic [CNT_W-1:0] REFL_B_CYC  = CNT_W'(REFL_B_MS * CYC_PER_MS);
	localparam logic [CNT_W-1:0] REFL_C_CYC  = CNT_W'(REFL_C_MS * CYC_PER_MS);

	// Register map, byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_HELD   = 8'h08;
	localparam logic [2:0] PAGE_CFG    = 3'h1;
	localparam logic [2:0] PAGE_MASK   = 3'h2;
	localparam int         CTRL_INDIV_BIT = 0;

	// Combining modes
	localparam logic [1:0] MODE_AND  = 2'h0;
	localparam logic [1:0] MODE_OR   = 2'h1;
	localparam logic [1:0] MODE_REFL = 2'h2;

	// Release interval selections
	localparam logic [1:0] IVL_500MS = 2'h0;
	localparam logic [1:0] IVL_1S    = 2'h1;
	localparam logic [1:0] IVL_2S    = 2'h2;

	// Per relay configuration, bit 0 is mode[0]
	typedef struct packed {
		logic [1:0] unit;
		logic       fail;
		logic       deen;
		logic [1:0] ivl;
		logic       ack_reset;
		logic       hold;
		logic [1:0] mode;
	} aor_cfg_t;

	localparam aor_cfg_t CFG_RST = '{unit: 2'h0, fail: 1'b0, deen: 1'b0, ivl: IVL_500MS,
		ack_reset: 1'b0, hold: 1'b0, mode: MODE_OR};
	localparam logic [NUM_ALARMS-1:0] MASK_RST = 16'h0000;
	localparam logic [31:0]           CTRL_RST = 32'h0000_0000;

	// Acknowledge commands
	typedef struct packed {
		logic       all;
		logic       one;
		logic [3:0] idx;
	} aor_ack_t;

	// System fault conditions
	typedef struct packed {
		logic                sys_fault;
		logic                crash;
		logic                acq_cpu;
		logic [NUM_SUBS-1:0] exp_cpu;
		logic [NUM_SUBS-1:0] link_down;
	} aor_fault_t;

	// Relay states
	typedef enum logic [3:0] {
		ST_OFF  = 4'b0001,
		ST_ON   = 4'b0010,
		ST_ACK  = 4'b0100,
		ST_REFL = 4'b1000
	} aor_state_t;

endpackage : aor_pkg

// >>> dv/aor_ops.sv
// Model of the alarm engine and operator buttons feeding the relay logic
`timescale 1ns/1ns
module aor_ops (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	// Requests from the bench
	input  wire logic [15:0]       lvl_req,
	input  wire aor_pkg::aor_ack_t ack_req,
	// Toward the relay logic
	output aor_pkg::aor_ack_t      ack,
	output logic      [15:0]       alarm_act
);
	import aor_pkg::*;
	// Levels and button pulses pass one edge late, as the engine registers them
	always_ff @(posedge ref_clk) begin
		alarm_act <= nrst ? lvl_req : 16'h0000;
		ack       <= nrst ? ack_req : '0;
	end
endmodule // aor_ops

// >>> dv/aor_monitor.sv
// Port checker for the alarm output relay logic
`timescale 1ns/1ns
module aor_monitor (
	// Clock and reset
	input wire logic               ref_clk,
	input wire logic               nrst,
	// Register port
	input wire logic [7:0]         reg_addr,
	input wire logic [31:0]        reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [31:0]        reg_rdata,
	// Alarm side and relays
	input wire logic [15:0]        alarm_act,
	input wire aor_pkg::aor_ack_t  ack,
	input wire aor_pkg::aor_fault_t fault,
	input wire logic [7:0]         relay_coil,
	input wire logic [15:0]        alarm_held
);
	import aor_pkg::*;
	default clocking mcb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Whole system down leaves no coil energized
	all_dead_a: assert property ((fault.crash || fault.acq_cpu) |=> relay_coil == 8'h00)
		else $error("coil energized during system failure");
	dead_bits_a: assert property (fault.crash [*2] ##0 (reg_rd && reg_addr == ADDR_STATUS)
		|=> reg_rdata[19:16] == 4'hF) else $error("dead units not reported");
	// Held indications only fall on an acknowledge
	held_keep_a: assert property (!ack.all && !ack.one
		|=> ($past(alarm_held) & ~alarm_held) == 16'h0000) else $error("held bit lost");
	ack_one_a: assert property (ack.one && !ack.all
		|=> (($past(alarm_held) & ~(16'h0001 << $past(ack.idx))) & ~alarm_held) == 16'h0000)
		else $error("individual ack cleared another alarm");
	ack_all_a: assert property (ack.all && (alarm_act | $past(alarm_act)) == 16'h0000
		|=> alarm_held == 16'h0000) else $error("global ack left held bits");
	// Read data stand only in the cycle after a read
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data without read");
	held_rd_a: assert property (reg_rd && reg_addr == ADDR_HELD
		|=> reg_rdata == {16'h0000, $past(alarm_held)}) else $error("held readback wrong");
	coil_rd_a: assert property (reg_rd && reg_addr == ADDR_STATUS
		|=> reg_rdata[15:8] == $past(relay_coil)) else $error("coil readback wrong");
	cover property (ack.all);
	cover property (ack.one);
	cover property (fault.crash);
endmodule // aor_monitor

bind aor_relay_logic aor_monitor aor_monitor_inst (.ref_clk(ref_clk), .nrst(nrst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .alarm_act(alarm_act), .ack(ack), .fault(fault),
	.relay_coil(relay_coil), .alarm_held(alarm_held));

// >>> dv/tb_top.sv
// Self-checking bench for the alarm output relay logic
`timescale 1ns/1ns
module tb_top;
	import aor_pkg::*;
	logic       ref_clk = 1'b0;
	logic       nrst    = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic       reg_wr = 1'b0, reg_rd = 1'b0;
	logic [15:0] lvl_req = 16'h0000, alarm_act, alarm_held;
	aor_ack_t   ack_req = '0, ack;
	aor_fault_t fault = '0;
	logic [7:0] relay_coil;
	int         error_cnt = 0, checked = 0;

	// Short windows keep the run brief
	aor_relay_logic #(.ACK_WIN_CYC(28'h014), .REFL_A_CYC(28'h01E), .REFL_B_CYC(28'h028),
		.REFL_C_CYC(28'h032)) aor_relay_logic_inst (.ref_clk(ref_clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .alarm_act(alarm_act), .ack(ack), .fault(fault),
		.relay_coil(relay_coil), .alarm_held(alarm_held));
	aor_ops aor_ops_inst (.ref_clk(ref_clk), .nrst(nrst), .lvl_req(lvl_req),
		.ack_req(ack_req), .ack(ack), .alarm_act(alarm_act));

	initial forever #4 ref_clk = ~ref_clk;

	task automatic end_of_test;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Sample one unit past the edge so the design's updates have landed
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cb(input int i, input logic e);
		ck("relay_coil bit", {31'h0, e}, {31'h0, relay_coil[i]});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		ck("reg_rdata", e, reg_rdata);
	endtask
	task automatic al(input logic [15:0] v, input int n);
		@(posedge ref_clk);
		lvl_req <= v;
		step(n);
	endtask
	task automatic ap(input logic a, input logic o, input logic [3:0] i);
		@(posedge ref_clk);
		ack_req <= '{all: a, one: o, idx: i};
		@(posedge ref_clk);
		ack_req <= '0;
		step(4);
	endtask
	task automatic fl(input logic [8:0] v, input logic [7:0] e);
		@(posedge ref_clk);
		fault <= aor_fault_t'(v);
		step(3);
		ck("relay_coil", {24'h0, e}, {24'h0, relay_coil});
	endtask

	task automatic t_regs;
		rd(8'h20, 32'h0000_0001);
		rd(8'h00, 32'h0000_0000);
		rd(8'h80, 32'h0000_0000);
		wr(8'h3C, 32'h0000_0080);
		rd(8'h3C, 32'h0000_00C0);
		step(2);
		cb(7, 1'b1);
		@(posedge ref_clk);
		fault <= aor_fault_t'(9'h100);
		step(3);
		cb(7, 1'b0);
		@(posedge ref_clk);
		fault <= '0;
	endtask
	task automatic t_comb;
		wr(8'h40, 32'h3);
		wr(8'h24, 32'h0);
		wr(8'h44, 32'h3);
		wr(8'h28, 32'h41);
		wr(8'h48, 32'h3);
		al(16'h0001, 5);
		cb(0, 1'b1);
		cb(1, 1'b0);
		cb(2, 1'b0);
		al(16'h0003, 4);
		cb(1, 1'b1);
		al(16'h0000, 4);
		cb(0, 1'b0);
		cb(2, 1'b1);
	endtask
	task automatic t_hold;
		wr(8'h2C, 32'h5);
		wr(8'h4C, 32'h10);
		al(16'h0010, 4);
		al(16'h0000, 4);
		cb(3, 1'b1);
		ap(1'b1, 1'b0, 4'h0);
		cb(3, 1'b0);
		ck("alarm_held", 32'h0, {16'h0, alarm_held});
		al(16'h0010, 4);
		ap(1'b1, 1'b0, 4'h0);
		cb(3, 1'b0);
		step(30);
		cb(3, 1'b1);
		al(16'h0000, 4);
		ap(1'b1, 1'b0, 4'h0);
		step(30);
		cb(3, 1'b0);
	endtask
	task automatic t_ack;
		wr(8'h2C, 32'hD);
		al(16'h0010, 4);
		ap(1'b1, 1'b0, 4'h0);
		step(30);
		cb(3, 1'b0);
		al(16'h0000, 4);
		al(16'h0010, 4);
		cb(3, 1'b1);
		wr(8'h2C, 32'h5);
		wr(8'h00, 32'h1);
		wr(8'h30, 32'h5);
		wr(8'h50, 32'h20);
		al(16'h0030, 4);
		al(16'h0010, 4);
		ap(1'b0, 1'b1, 4'h4);
		step(30);
		cb(3, 1'b0);
		cb(4, 1'b1);
		ck("held bit 5", 32'h1, {31'h0, alarm_held[5]});
		rd(8'h08, 32'h0000_0030);
		al(16'h0000, 4);
		ap(1'b1, 1'b0, 4'h0);
		wr(8'h00, 32'h0);
	endtask
	// Hold bit set on purpose: a reflash relay must still act non-hold
	task automatic t_refl;
		wr(8'h54, 32'hC0);
		for (int k = 0; k < 3; k++) begin
			wr(8'h34, 32'h6 | (k << 4));
			al(16'h0040, 4);
			cb(5, 1'b1);
			al(16'h00C0, 30 + 10 * k);
			cb(5, 1'b0);
			step(6);
			cb(5, 1'b1);
			al(16'h0000, 4);
			cb(5, 1'b0);
		end
	endtask
	task automatic t_fault;
		wr(8'h30, 32'h101);
		wr(8'h34, 32'h201);
		wr(8'h38, 32'h301);
		wr(8'h50, 32'h100);
		wr(8'h54, 32'h100);
		wr(8'h58, 32'h100);
		wr(8'h40, 32'h100);
		al(16'h0100, 4);
		fl(9'h002, 8'h95);
		fl(9'h000, 8'hF5);
		fl(9'h008, 8'hE5);
		fl(9'h080, 8'h00);
		rd(8'h04, 32'h000F_0071);
		fl(9'h040, 8'h00);
		fl(9'h000, 8'hF5);
	endtask

	// Watchdog sized well above the roughly 500 cycles the tests need
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		$display("watchdog expired");
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		t_regs();
		t_comb();
		t_hold();
		t_ack();
		t_refl();
		t_fault();
		end_of_test();
	end
endmodule // tb_top
